// File: aspc_device.sv
// Converter end of the serial port: shifts the link in the link clock domain
// and keeps control, calibration and conversion words in the system domain.
// Assumes the host holds register select steady through a frame and gives
// at least two system clocks between a frame sync edge and the first clock.
//
// Notes on behaviour
// - Host lowers transmit sync to write.
// - Self clock starts only after transmit or receive sync.
// - Host lowers transmit sync before first bit.
// - Self mode: clock and data after receive sync.
// - External mode: data driven after receive sync.
// - New conversion word pulls data ready low, unless it arrives during a receive frame.
// - Data ready rises after full conversion word read.
// - Calibration end also pulls data ready low.
// - Conversion read drives only if data ready low.
// - Write bits sampled on rising clock edges.
// - Unipolar natural binary, bipolar offset binary.
// - Select low reaches the control register.
// - Control loads only after full 24 bits.
// - Clock pulses beyond the 24th are ignored.
// - Host reads all 24 control bits.
// - Data line is bidirectional.
// - Select high in normal mode reads conversions.
`timescale 1ns/1ps
module aspc_device
  import aspc_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 self_clock_mode_in,
  input  wire logic                 conv_valid_in,
  input  wire logic [WORD_BITS-1:0] conv_word_in,
  input  wire logic                 cal_done_in,
  output logic      [WORD_BITS-1:0] ctrl_word_out,
  output logic      [WORD_BITS-1:0] cal_word_out,
  aspc_link_if.device               link
);

  // ---------------------------------------------------------------------------
  // Shared state
  // ---------------------------------------------------------------------------
  logic [WORD_BITS-1:0] ctrl_q;
  logic [WORD_BITS-1:0] cal_q;
  logic [WORD_BITS-1:0] conv_hold_q;
  logic                 data_ready_n_q;
  logic                 self_mode_q;
  logic [CNT_W-1:0]     bit_cnt_q;
  logic                 wr_done_q;
  logic                 rd_done_q;
  logic [WORD_BITS-1:0] wr_shift_q;
  logic [WORD_BITS-1:0] rd_shift_q;
  logic                 serial_data_io_out_q;
  logic                 serial_data_io_oe_n_q;
  logic                 frame_idle;
  logic                 conv_read;
  logic                 read_ok;
  logic [WORD_BITS-1:0] read_src;

  function automatic logic mode_normal(input logic [WORD_BITS-1:0] ctrl);
    return ctrl[MODE_HI:MODE_LO] == 3'h0;
  endfunction

  // ---------------------------------------------------------------------------
  // Link clock domain
  // ---------------------------------------------------------------------------
  // The link clock stops between frames, so frame state is cleared by the frame
  // syncs themselves rather than by a clocked reset.
  assign frame_idle = link.transmit_frame_sync_n & link.receive_frame_sync_n;

  // The stored words are read directly here; the system side loads them at the end of a write frame or
  // outside receive frames, but a calibration end clears the control mode field at any time except in the cycle of a wr_commit.
  assign conv_read = link.register_select & mode_normal(ctrl_q);
  assign read_ok   = !conv_read || !data_ready_n_q;
  always_comb begin
    if (!link.register_select) begin
      read_src = ctrl_q;
    end else if (conv_read) begin
      read_src = conv_hold_q;
    end else begin
      read_src = cal_q;
    end
  end

  always_ff @(posedge link.sclk or posedge frame_idle) begin
    if (frame_idle) begin
      bit_cnt_q <= '0;
      wr_done_q <= 1'b0;
      rd_done_q <= 1'b0;
    end else if (bit_cnt_q != WORD_COUNT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      if (bit_cnt_q == LAST_BIT) begin
        wr_done_q <= !link.transmit_frame_sync_n;
        rd_done_q <= !link.receive_frame_sync_n;
      end
    end
  end

  always_ff @(posedge link.sclk) begin
    if (!link.transmit_frame_sync_n && bit_cnt_q != WORD_COUNT) begin
      wr_shift_q <= {wr_shift_q[WORD_BITS-2:0], link.serial_data_io};
    end
  end

  // Read bits change on falling edges so the host can take them on rising ones.
  always_ff @(negedge link.sclk or posedge link.receive_frame_sync_n) begin
    if (link.receive_frame_sync_n) begin
      serial_data_io_oe_n_q <= 1'b1;
      serial_data_io_out_q  <= 1'b1;
      rd_shift_q   <= '0;
    end else if (bit_cnt_q == '0) begin
      serial_data_io_oe_n_q <= !read_ok;
      serial_data_io_out_q  <= read_src[WORD_BITS-1];
      rd_shift_q   <= {read_src[WORD_BITS-2:0], 1'b0};
    end else begin
      serial_data_io_out_q <= rd_shift_q[WORD_BITS-1];
      rd_shift_q  <= {rd_shift_q[WORD_BITS-2:0], 1'b0};
    end
  end

  assign link.dev_serial_data_io_out  = serial_data_io_out_q;
  assign link.dev_serial_data_io_oe_n = serial_data_io_oe_n_q;

  // ---------------------------------------------------------------------------
  // Crossing into the system domain
  // ---------------------------------------------------------------------------
  logic tfs_s;
  logic rfs_s;
  logic sel_s;
  logic wr_done_s;
  logic rd_done_s;
  logic wr_done_d_q;
  logic rd_done_d_q;
  logic wr_commit;
  logic rd_finish;

  aspc_sync #(
    .WIDTH       (5),
    .RESET_VALUE (5'h18)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({link.transmit_frame_sync_n, link.receive_frame_sync_n,
                link.register_select, wr_done_q, rd_done_q}),
    .sync_out ({tfs_s, rfs_s, sel_s, wr_done_s, rd_done_s})
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_done_d_q <= 1'b0;
      rd_done_d_q <= 1'b0;
      self_mode_q <= 1'b0;
    end else begin
      wr_done_d_q <= wr_done_s;
      rd_done_d_q <= rd_done_s;
      self_mode_q <= self_clock_mode_in;
    end
  end

  assign wr_commit = wr_done_s & ~wr_done_d_q;
  assign rd_finish = rd_done_s & ~rd_done_d_q;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // The shift word is frozen once 24 bits are in, so it is safe to copy here.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RESET;
      cal_q  <= CAL_RESET;
    end else if (wr_commit) begin
      if (!sel_s) begin
        ctrl_q <= wr_shift_q;
      end else begin
        cal_q <= wr_shift_q;
      end
    end else if (cal_done_in) begin
      ctrl_q[MODE_HI:MODE_LO] <= 3'h0;
    end
  end

  // A word that arrives during a receive frame is dropped; loading it would
  // change the word being shifted out.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      conv_hold_q <= CONV_RESET;
    end else if (conv_valid_in && rfs_s) begin
      if (ctrl_q[UNIPOLAR_BIT]) begin
        conv_hold_q <= conv_word_in;
      end else begin
        conv_hold_q <= {~conv_word_in[WORD_BITS-1], conv_word_in[WORD_BITS-2:0]};
      end
    end
  end

  // A calibration end in the same cycle as the end of a read keeps the line low.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      data_ready_n_q <= 1'b1;
    end else if ((conv_valid_in && rfs_s) || cal_done_in) begin
      data_ready_n_q <= 1'b0;
    end else if (rd_finish && sel_s && mode_normal(ctrl_q)) begin
      data_ready_n_q <= 1'b1;
    end
  end

  assign link.data_ready_n = data_ready_n_q;
  assign ctrl_word_out     = ctrl_q;
  assign cal_word_out      = cal_q;

  // ---------------------------------------------------------------------------
  // Self clock generator
  // ---------------------------------------------------------------------------
  logic             gen_active;
  logic [DIV_W-1:0] div_cnt_q;
  logic [CNT_W-1:0] edge_cnt_q;
  logic             sclk_out_q;
  logic             sclk_oe_n_q;

  assign gen_active = self_mode_q & (~tfs_s | ~rfs_s);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !gen_active) begin
      div_cnt_q   <= '0;
      edge_cnt_q  <= '0;
      sclk_out_q  <= 1'b1;
      sclk_oe_n_q <= 1'b1;
    end else begin
      sclk_oe_n_q <= 1'b0;
      if (edge_cnt_q != WORD_COUNT) begin
        if (div_cnt_q == HALF_LAST) begin
          div_cnt_q  <= '0;
          sclk_out_q <= ~sclk_out_q;
          if (!sclk_out_q) begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
          end
        end else begin
          div_cnt_q <= div_cnt_q + 4'h1;
        end
      end
    end
  end

  assign link.dev_sclk_out  = sclk_out_q;
  assign link.dev_sclk_oe_n = sclk_oe_n_q;

endmodule

// File: aspc_pkg.sv
// Shared constants for the converter serial port: word size, control field
// positions, reset values and timing counts.
// Assumes a 40 MHz system clock on both ends of the link.
package aspc_pkg;

  // ---------------------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_BITS  = 24;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] WORD_COUNT = 5'h18;
  localparam logic [CNT_W-1:0] LAST_BIT   = 5'h17;

  // Operating mode field and coding select bit of the control word.
  localparam int unsigned MODE_HI      = 23;
  localparam int unsigned MODE_LO      = 21;
  localparam int unsigned UNIPOLAR_BIT = 12;

  localparam logic [WORD_BITS-1:0] CTRL_RESET = 24'h000000;
  localparam logic [WORD_BITS-1:0] CAL_RESET  = 24'h000000;
  localparam logic [WORD_BITS-1:0] CONV_RESET = 24'h000000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SCLK_HALF_NS  = 100;
  localparam int unsigned SETUP_NS      = 200;
  localparam int unsigned HALF_CYCLES   = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYCLES  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 4;
  localparam logic [DIV_W-1:0] HALF_LAST  = DIV_W'(HALF_CYCLES - 1);
  localparam logic [DIV_W-1:0] SETUP_LAST = DIV_W'(SETUP_CYCLES - 1);

endpackage

// File: aspc_link_if.sv
// Pin bundle between the converter port and its host controller.
// The two shared lines are resolved here from the output enables; an
// undriven line reads high, as with an external pull-up.
`timescale 1ns/1ps
interface aspc_link_if;
  logic transmit_frame_sync_n;
  logic receive_frame_sync_n;
  logic register_select;
  logic data_ready_n;
  logic host_serial_data_io_out;
  logic host_serial_data_io_oe_n;
  logic dev_serial_data_io_out;
  logic dev_serial_data_io_oe_n;
  logic host_sclk_out;
  logic host_sclk_oe_n;
  logic dev_sclk_out;
  logic dev_sclk_oe_n;
  logic serial_data_io;
  logic sclk;

  assign serial_data_io = !dev_serial_data_io_oe_n ? dev_serial_data_io_out :
                          !host_serial_data_io_oe_n ? host_serial_data_io_out : 1'b1;
  assign sclk = !dev_sclk_oe_n ? dev_sclk_out :
                !host_sclk_oe_n ? host_sclk_out : 1'b1;

  modport device (
    input  transmit_frame_sync_n, receive_frame_sync_n, register_select,
    input  serial_data_io, sclk,
    output data_ready_n, dev_serial_data_io_out, dev_serial_data_io_oe_n, dev_sclk_out, dev_sclk_oe_n
  );
  modport host (
    output transmit_frame_sync_n, receive_frame_sync_n, register_select,
    output host_serial_data_io_out, host_serial_data_io_oe_n, host_sclk_out, host_sclk_oe_n,
    input  serial_data_io, sclk, data_ready_n
  );
endinterface

// File: aspc_sync.sv
// Two-flop level synchroniser, one stage pair per bit.
// Assumes each input bit is an independent level; words need a handshake.
`timescale 1ns/1ps
module aspc_sync #(
  parameter int unsigned     WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: aspc_host.sv
// Host controller end: runs one 24-bit write or read frame per command.
// Assumes the converter end shares the mode strap given on self_clock_mode_in.
`timescale 1ns/1ps
module aspc_host
  import aspc_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 self_clock_mode_in,
  input  wire logic                 cmd_valid_in,
  input  wire logic                 cmd_write_in,
  input  wire logic                 cmd_select_in,
  input  wire logic [WORD_BITS-1:0] cmd_word_in,
  output logic                      cmd_ready_out,
  output logic                      rsp_valid_out,
  output logic      [WORD_BITS-1:0] rsp_word_out,
  output logic                      data_ready_seen_n_out,
  aspc_link_if.host                 link
);

  // ---------------------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------------------
  logic sclk_s;
  logic serial_data_io_s;
  logic sclk_prev_q;

  aspc_sync #(
    .WIDTH       (3),
    .RESET_VALUE (3'h7)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({link.sclk, link.serial_data_io, link.data_ready_n}),
    .sync_out ({sclk_s, serial_data_io_s, data_ready_seen_n_out})
  );

  // ---------------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b10,
    H_END   = 2'b11
  } aspc_host_state_t;

  aspc_host_state_t     state_q;
  logic                 self_mode_q;
  logic                 write_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [CNT_W-1:0]     bits_q;
  logic [DIV_W-1:0]     div_q;
  logic                 sclk_q;
  logic                 tfs_n_q;
  logic                 rfs_n_q;
  logic                 sel_q;
  logic                 serial_data_io_q;
  logic                 serial_data_io_oe_n_q;
  logic                 toggle;
  logic                 fall_ev;
  logic                 rise_ev;

  assign toggle  = !self_mode_q && state_q == H_SHIFT && div_q == HALF_LAST;
  assign fall_ev = self_mode_q ? (sclk_prev_q & ~sclk_s) : (toggle & sclk_q);
  assign rise_ev = self_mode_q ? (~sclk_prev_q & sclk_s) : (toggle & ~sclk_q);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q       <= H_IDLE;
      self_mode_q   <= 1'b0;
      write_q       <= 1'b0;
      bits_q        <= '0;
      div_q         <= '0;
      sclk_prev_q   <= 1'b1;
      sclk_q        <= 1'b1;
      tfs_n_q       <= 1'b1;
      rfs_n_q       <= 1'b1;
      sel_q         <= 1'b0;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
    end else begin
      sclk_prev_q   <= sclk_s;
      rsp_valid_out <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          cmd_ready_out <= 1'b1;
          self_mode_q   <= self_clock_mode_in;
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            write_q       <= cmd_write_in;
            sel_q         <= cmd_select_in;
            tfs_n_q       <= !cmd_write_in;
            rfs_n_q       <= cmd_write_in;
            bits_q        <= '0;
            div_q         <= '0;
            // The converter's own clock starts by itself, so no setup wait.
            state_q       <= self_clock_mode_in ? H_SHIFT : H_SETUP;
          end
        end
        H_SETUP: begin
          div_q <= div_q + 4'h1;
          if (div_q == SETUP_LAST) begin
            div_q   <= '0;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_q <= toggle ? '0 : div_q + 4'h1;
          if (toggle) begin
            sclk_q <= ~sclk_q;
          end
          if (rise_ev) begin
            bits_q <= bits_q + 5'h01;
            if (bits_q == LAST_BIT) begin
              state_q <= H_END;
            end
          end
        end
        H_END: begin
          tfs_n_q       <= 1'b1;
          rfs_n_q       <= 1'b1;
          rsp_valid_out <= !write_q;
          state_q       <= H_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------------------
  // Write bits change on falling edges; read bits are taken on rising edges.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift_q      <= '0;
      serial_data_io_q      <= 1'b1;
      serial_data_io_oe_n_q <= 1'b1;
      rsp_word_out <= '0;
    end else if (state_q == H_IDLE && cmd_valid_in && cmd_ready_out) begin
      shift_q      <= cmd_word_in;
      serial_data_io_q      <= cmd_word_in[WORD_BITS-1];
      serial_data_io_oe_n_q <= !cmd_write_in;
    end else if (state_q == H_SHIFT) begin
      if (write_q && fall_ev) begin
        serial_data_io_q <= shift_q[WORD_BITS-1];
        shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
      end else if (!write_q && rise_ev) begin
        shift_q <= {shift_q[WORD_BITS-2:0], serial_data_io_s};
      end
    end else if (state_q == H_END) begin
      serial_data_io_oe_n_q <= 1'b1;
      rsp_word_out <= shift_q;
    end
  end

  assign link.transmit_frame_sync_n = tfs_n_q;
  assign link.receive_frame_sync_n  = rfs_n_q;
  assign link.register_select       = sel_q;
  assign link.host_serial_data_io_out        = serial_data_io_q;
  assign link.host_serial_data_io_oe_n       = serial_data_io_oe_n_q;
  assign link.host_sclk_out         = sclk_q;
  assign link.host_sclk_oe_n        = self_mode_q;

endmodule

// File: aspc_link_chk.sv
// Checker for the converter serial link, fed with the interface's signals.
// Assumes both ends run on clk_in and the link clock is far slower than it.
`timescale 1ns/1ps
module aspc_link_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic transmit_frame_sync_n,
  input wire logic receive_frame_sync_n,
  input wire logic data_ready_n,
  input wire logic dev_serial_data_io_oe_n,
  input wire logic dev_sclk_oe_n,
  input wire logic serial_data_io,
  input wire logic sclk
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------------------
  logic       idle;
  logic       idle_q;
  logic       sclk_q;
  logic       rd_q;
  logic [5:0] rise_q;
  assign idle = transmit_frame_sync_n && receive_frame_sync_n;
  // The count survives the frame end, so a late data ready edge still sees it.
  always_ff @(posedge clk_in) begin
    idle_q <= !rst_n_in || idle;
    sclk_q <= !rst_n_in || sclk;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rise_q <= 6'h00;
      rd_q   <= 1'b0;
    end else if (!idle && idle_q) begin
      rise_q <= 6'h00;
      rd_q   <= !receive_frame_sync_n;
    end else if (!idle && sclk && !sclk_q) begin
      rise_q <= rise_q + 6'h01;
    end
  end
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_frame_pulse_count: assert property ($rose(transmit_frame_sync_n) |-> rise_q == 6'h18)
    else $error("write frame did not carry 24 clock rises");
  a_rdy_after_read: assert property ($rose(data_ready_n) |-> rd_q && rise_q == 6'h18)
    else $error("data ready rose without a full read");
  a_idle_data_off: assert property (idle && $past(idle) |-> dev_serial_data_io_oe_n)
    else $error("device drives data while idle");
  // The self clock stops only after the syncs have crossed the two-flop synchroniser.
  a_idle_clk_off: assert property (idle && $past(idle) && $past(idle, 2)
    && $past(idle, 3) |-> dev_sclk_oe_n && sclk)
    else $error("link clock active while idle");
  a_data_after_rfs: assert property ($fell(dev_serial_data_io_oe_n) |-> !receive_frame_sync_n)
    else $error("device data driven without receive sync");
  a_write_data_quiet: assert property (!transmit_frame_sync_n && receive_frame_sync_n
    && $past(receive_frame_sync_n) |-> dev_serial_data_io_oe_n)
    else $error("device drives data during a write");
  a_clk_after_sync: assert property ($fell(dev_sclk_oe_n) |-> !idle)
    else $error("self clock started outside a frame");
  a_data_steady_rise: assert property ($rose(sclk) && !dev_serial_data_io_oe_n
    |-> $stable(serial_data_io))
    else $error("read data changed at a rising clock edge");
  a_sync_leads_clk: assert property ($fell(transmit_frame_sync_n) |-> sclk [*2])
    else $error("clock edge too close to transmit sync");
  c_rdy_release: cover property ($rose(data_ready_n));
  c_self_clock: cover property ($fell(dev_sclk_oe_n));
  c_write_end: cover property ($rose(transmit_frame_sync_n));
endmodule

// File: testbench.sv
// Self-checking bench: a host and a converter joined by one link, plus a
// second converter whose link is driven by hand to break the frame rules.
// Assumes one 40 MHz clock for all three ends.
`timescale 1ns/1ps
module testbench;
  import aspc_pkg::*;
  logic                 clk_in;
  logic                 rst_n_in;
  logic                 self_mode;
  logic                 conv_valid;
  logic [WORD_BITS-1:0] conv_word;
  logic                 cal_done;
  logic [WORD_BITS-1:0] ctrl_word;
  logic [WORD_BITS-1:0] cal_word;
  logic [WORD_BITS-1:0] ctrl_b;
  logic [WORD_BITS-1:0] cal_b;
  logic                 cmd_valid;
  logic                 cmd_write;
  logic                 cmd_select;
  logic [WORD_BITS-1:0] cmd_word;
  logic                 cmd_ready;
  logic                 rsp_valid;
  logic [WORD_BITS-1:0] rsp_word;
  logic                 seen_n;
  logic [31:0]          rng;
  logic [WORD_BITS-1:0] w;
  logic [WORD_BITS-1:0] c;
  logic [WORD_BITS-1:0] got;
  int                   bad_count;
  int                   n_tests;
  aspc_link_if lk ();
  aspc_link_if lk2 ();
  aspc_device aspc_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .self_clock_mode_in(self_mode), .conv_valid_in(conv_valid), .conv_word_in(conv_word),
    .cal_done_in(cal_done), .ctrl_word_out(ctrl_word), .cal_word_out(cal_word), .link(lk));
  aspc_device aspc_device_fault_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .self_clock_mode_in(1'b0), .conv_valid_in(1'b0), .conv_word_in(24'h000000),
    .cal_done_in(1'b0), .ctrl_word_out(ctrl_b), .cal_word_out(cal_b), .link(lk2));
  aspc_host aspc_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .self_clock_mode_in(self_mode), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_select_in(cmd_select), .cmd_word_in(cmd_word), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_word_out(rsp_word), .data_ready_seen_n_out(seen_n),
    .link(lk));
  aspc_link_chk aspc_link_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .transmit_frame_sync_n(lk.transmit_frame_sync_n),
    .receive_frame_sync_n(lk.receive_frame_sync_n), .data_ready_n(lk.data_ready_n),
    .dev_serial_data_io_oe_n(lk.dev_serial_data_io_oe_n), .dev_sclk_oe_n(lk.dev_sclk_oe_n),
    .serial_data_io(lk.serial_data_io), .sclk(lk.sclk));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic void rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
  endfunction
  // Offset binary is the two's complement input with its sign bit flipped.
  function automatic logic [23:0] coded(input logic [23:0] x, input logic [23:0] ctl);
    return ctl[UNIPOLAR_BIT] ? x : x ^ 24'h800000;
  endfunction
  task automatic bounded(input logic ok, input int i);
    if (!ok && i >= 4000) begin
      bad_count++;
      $display("[ERR] handshake expected 1 seen 0");
      print_verdict();
    end
  endtask
  task automatic do_cmd(input logic wr, input logic sel, input logic [23:0] word);
    int i;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_select = sel;
    cmd_word = word;
    for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++) tick(1);
    bounded(cmd_ready === 1'b1, i);
    tick(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 4000 && (wr ? cmd_ready : rsp_valid) !== 1'b1; i++) tick(1);
    bounded((wr ? cmd_ready : rsp_valid) === 1'b1, i);
    got = rsp_word;
    tick(10);
  endtask
  // Hand-made external-clock write on the second link, its clock at a 12 ns period with
  // no phase tie to clk_in; bits past 24 are junk.
  task automatic bang(input int n, input logic sel, input logic [23:0] word);
    lk2.register_select = sel;
    lk2.transmit_frame_sync_n = 1'b0;
    lk2.host_serial_data_io_oe_n = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      lk2.host_sclk_out = 1'b0;
      lk2.host_serial_data_io_out = (i < 24) ? word[23-i] : ~word[0];
      #6;
      lk2.host_sclk_out = 1'b1;
      #6;
    end
    // Hold the sync long enough for the converter to see the frame as complete.
    tick(4);
    lk2.transmit_frame_sync_n = 1'b1;
    lk2.host_serial_data_io_oe_n = 1'b1;
    tick(8);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {bad_count, n_tests} = '0;
    rng = 32'h00000052;
    {self_mode, conv_valid, cal_done, cmd_valid, cmd_write, cmd_select} = '0;
    {conv_word, cmd_word} = '0;
    {lk2.transmit_frame_sync_n, lk2.receive_frame_sync_n, lk2.host_sclk_out} = 3'h5;
    {lk2.host_serial_data_io_oe_n, lk2.host_serial_data_io_out, lk2.host_sclk_oe_n} = 3'h6;
    lk2.register_select = 1'b0;
    rst_n_in = 1'b0;
    tick(12);
    // The second converter's link flops have no reset; a rising receive sync clears them.
    lk2.receive_frame_sync_n = 1'b1;
    rst_n_in = 1'b1;
    tick(2);
    check("ctrl reset", CTRL_RESET, ctrl_word);
    check("cal reset", CAL_RESET, cal_word);
    check("ready idle", 24'h000001, {23'h0, lk.data_ready_n});
    do_cmd(1'b0, 1'b1, 24'h000000);
    check("stale conv read", 24'hffffff, got);
    for (int m = 0; m < 2; m++) begin
      self_mode = m[0];
      tick(8);
      for (int k = 0; k < 4; k++) begin
        rnd();
        w = (k == 0) ? 24'h1fffff : (k == 1) ? 24'h000000 : rng[23:0] & 24'h1fffff;
        do_cmd(1'b1, 1'b0, w);
        check("ctrl write", w, ctrl_word);
        do_cmd(1'b0, 1'b0, 24'h000000);
        check("ctrl read", w, got);
        rnd();
        c = (k == 1) ? 24'h800000 : rng[31:8];
        conv_word = c;
        conv_valid = 1'b1;
        tick(1);
        conv_valid = 1'b0;
        tick(1);
        check("ready on new word", 24'h000000, {23'h0, lk.data_ready_n});
        tick(4);
        check("host ready view", 24'h000000, {23'h0, seen_n});
        do_cmd(1'b0, 1'b1, 24'h000000);
        check("conv read", coded(c, w), got);
        check("ready after read", 24'h000001, {23'h0, lk.data_ready_n});
      end
      rnd();
      w = (rng[23:0] & 24'h1fffff) | 24'h200000;
      do_cmd(1'b1, 1'b0, w);
      rnd();
      do_cmd(1'b1, 1'b1, rng[23:0]);
      check("cal write", rng[23:0], cal_word);
      do_cmd(1'b0, 1'b1, 24'h000000);
      check("cal read", rng[23:0], got);
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
      tick(4);
      check("mode after cal", w & 24'h1fffff, ctrl_word);
      check("ready after cal", 24'h000000, {23'h0, lk.data_ready_n});
      do_cmd(1'b0, 1'b1, 24'h000000);
      check("ready after cal read", 24'h000001, {23'h0, lk.data_ready_n});
    end
    rnd();
    bang(24, 1'b0, rng[23:0]);
    check("full frame", rng[23:0], ctrl_b);
    bang(12, 1'b0, ~rng[23:0]);
    check("short frame", rng[23:0], ctrl_b);
    bang(30, 1'b0, rng[31:8]);
    check("long frame", rng[31:8], ctrl_b);
    bang(24, 1'b1, ~rng[31:8]);
    check("cal frame", ~rng[31:8], cal_b);
    print_verdict();
  end
endmodule
